// ### design/csc_clock_control.sv
// clock source selection, start-up sequencing and clock domain gating
// assumes all tick and level inputs are synchronous to aclk
//
// Summary of operation
// R01 - decode four fuse bits into crystal, RC or external clock source
// R02 - fuse bit one is unprogrammed, zero is programmed
// R03 - reset default: calibrated RC, divide by eight, longest start-up
// R04 - hold internal reset a time-out after other resets release
// R05 - time-out counts 0, 512 or 8192 watchdog oscillator cycles
// R06 - oscillator cycle counter holds reset until start-up count elapses
// R07 - reset start uses time-out plus start-up; wake uses start-up only
// R08 - low power crystal upper select bits give the frequency range
// R09 - low power crystal start-up count: 258, 1K or 16K cycles
// R10 - low power crystal reset delay: 14 cycles plus chosen time-out
// R11 - every clock domain except the async timer runs at the prescaler output rate
// R12 - unused clock domains halt independently per sleep mode
// R13 - program memory clock gates together with the core clock
// R14 - async timer clock runs from its own source in every sleep mode but power-down
// R15 - converter clock stays on while core and peripherals halt
// R16 - level wake must hold until start-up ends, else no interrupt
// R17 - programmed divide fuse divides the internal clock by eight
// R18 - fuses sampled during reset and held constant while running
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module csc_clock_control
(
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite slave
	input  wire logic [3:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [3:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// fuses, oscillators, reset and wake sources
	input  wire csc_pkg::csc_fuse_t   fuses,
	input  wire logic                 other_reset_active,
	input  wire logic                 osc_tick,
	input  wire logic                 watchdog_tick,
	input  wire logic                 async_source_tick,
	input  wire logic                 wake_event,
	input  wire logic                 wake_level,
	// outputs
	output logic                      internal_reset,
	output csc_pkg::csc_domain_t      domain_en,
	output logic                      wake_interrupt,
	output logic [2:0]                lp_freq_range
);
	import csc_pkg::*;

	typedef struct packed
	{
		csc_state_t  st;
		csc_fuse_t   fz;
		logic [14:0] cnt;
		logic        reset_o;
		logic        wake_irq;
		csc_sleep_t  mode;
		logic        aw_got;
		logic [3:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} csc_state_s_t;

	localparam csc_state_s_t RESET_S = '{
		st: CSC_ST_HOLD,
		fz: '{CSC_DEF_SRC_SEL, CSC_DEF_SUT, CSC_DEF_DIV8},
		cnt: '0, reset_o: 1'b1, wake_irq: 1'b0, mode: CSC_SLP_IDLE,
		aw_got: 1'b0, aw_addr: '0, w_got: 1'b0, w_data: '0, w_strb: '0,
		bvalid: 1'b0, bresp: CSC_RESP_OKAY, rvalid: 1'b0, rdata: '0,
		rresp: CSC_RESP_OKAY};

	csc_state_s_t s_r;
	csc_state_s_t s_nxt;
	logic         sys_tick;

	// low power crystal: select fuses at or above CSC_SRC_LP_LO
	function automatic logic is_lp(input csc_fuse_t f);
		return f.clock_source_select_fuses >= CSC_SRC_LP_LO; // R01
	endfunction

	// watchdog time-out count for a reset start
	function automatic logic [14:0] tout_count(input csc_fuse_t f);
		logic [2:0] code;
		code = {f.clock_source_select_fuses[0], f.startup_time_fuses};
		if (is_lp(f))
		begin
			if (code == 3'h2 || code == 3'h5)
				return CSC_TOUT_NONE; // R10
			else if (code == 3'h0 || code == 3'h3 || code == 3'h6)
				return CSC_TOUT_SHORT; // R10
			else
				return CSC_TOUT_LONG; // R10
		end
		else if (f.startup_time_fuses == 2'h0)
			return CSC_TOUT_NONE; // R05
		else if (f.startup_time_fuses == 2'h1)
			return CSC_TOUT_SHORT; // R05
		else
			return CSC_TOUT_LONG; // R05
	endfunction

	// oscillator start-up count, used on both reset and wake
	function automatic logic [14:0] su_count(input csc_fuse_t f);
		logic [2:0] code;
		code = {f.clock_source_select_fuses[0], f.startup_time_fuses};
		if (is_lp(f))
		begin
			if (code <= 3'h1)
				return CSC_SU_258; // R09
			else if (code <= 3'h4)
				return CSC_SU_1K; // R09
			else
				return CSC_SU_16K; // R09
		end
		else if (f.clock_source_select_fuses == CSC_SRC_EXT)
			return CSC_SU_EXT;
		else if (f.clock_source_select_fuses <= CSC_SRC_RC_128K)
			return CSC_SU_EXT;
		else
			return CSC_SU_1K;
	endfunction

	// prescaler shared by every domain but the async timer
	csc_prescaler u_pre
	(
		.aclk     (aclk),
		.aresetn  (aresetn),
		.divide   (s_r.fz.divide_by_eight_fuse == CSC_FUSE_PROG), // R02 R17
		.osc_tick (osc_tick),
		.sys_tick (sys_tick)
	);

	// sequencer and register slave
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.wake_irq = 1'b0;
		case (s_r.st)
			CSC_ST_HOLD:
			begin
				s_nxt.fz = fuses; // R18
				s_nxt.reset_o = 1'b1;
				if (!other_reset_active)
				begin
					s_nxt.st = CSC_ST_TOUT; // R04
					s_nxt.cnt = tout_count(fuses);
				end
			end
			CSC_ST_TOUT:
			begin
				if (s_r.cnt == '0)
				begin
					s_nxt.st = is_lp(s_r.fz) ? CSC_ST_EXTRA : CSC_ST_START;
					s_nxt.cnt = is_lp(s_r.fz) ? CSC_RESET_EXTRA
						: su_count(s_r.fz);
				end
				else if (watchdog_tick)
					s_nxt.cnt = s_r.cnt - 1'b1; // R05
			end
			CSC_ST_EXTRA:
			begin
				if (s_r.cnt == '0)
				begin
					s_nxt.st = CSC_ST_START; // R07
					s_nxt.cnt = su_count(s_r.fz);
				end
				else if (osc_tick)
					s_nxt.cnt = s_r.cnt - 1'b1; // R10
			end
			CSC_ST_START, CSC_ST_WAKE:
			begin
				if (s_r.cnt == '0)
				begin
					s_nxt.st = CSC_ST_RUN;
					s_nxt.reset_o = 1'b0; // R06
					s_nxt.wake_irq = (s_r.st == CSC_ST_WAKE) && wake_level; // R16
				end
				else if (osc_tick)
					s_nxt.cnt = s_r.cnt - 1'b1; // R06
			end
			CSC_ST_RUN:
			begin
				if (s_r.w_got && s_r.aw_got && !s_r.bvalid
					&& s_r.aw_addr == CSC_REG_CTRL && s_r.w_strb[0]
					&& s_r.w_data[CSC_CTRL_GO_BIT])
					s_nxt.st = CSC_ST_SLEEP;
			end
			CSC_ST_SLEEP:
			begin
				if (wake_event || wake_level)
				begin
					s_nxt.st = CSC_ST_WAKE; // R07
					s_nxt.cnt = su_count(s_r.fz);
				end
			end
			default:
				s_nxt.st = CSC_ST_HOLD;
		endcase

		// write channel: address and data taken in either order
		if (s_axi_awvalid && !s_r.aw_got)
		begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_got)
		begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
		begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = CSC_RESP_OKAY;
			if (s_r.aw_addr == CSC_REG_CTRL)
			begin
				if (s_r.w_strb[0])
					s_nxt.mode = csc_sleep_t'(s_r.w_data[2:0]);
			end
			else if (s_r.aw_addr != CSC_REG_STATUS)
				s_nxt.bresp = CSC_RESP_SLVERR;
		end
		if (s_r.bvalid && s_axi_bready)
		begin
			s_nxt.bvalid = 1'b0;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
		end

		// read channel
		if (s_axi_arvalid && !s_r.rvalid)
		begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = CSC_RESP_OKAY;
			if (s_axi_araddr == CSC_REG_CTRL)
				s_nxt.rdata = {29'h0, s_r.mode};
			else if (s_axi_araddr == CSC_REG_STATUS)
				s_nxt.rdata = {16'h0, 5'h0, s_r.st, 1'b0, s_r.fz};
			else
			begin
				s_nxt.rdata = '0;
				s_nxt.rresp = CSC_RESP_SLVERR;
			end
		end
		else if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
	end

	// one register for the whole state
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_r <= RESET_S; // R03
		else
			s_r <= s_nxt;
	end

	// domain gating: prescaler rate for all but the async timer, halted per sleep mode
	logic run_on;
	logic slp;
	assign run_on = (s_r.st == CSC_ST_RUN);
	assign slp = (s_r.st == CSC_ST_SLEEP) || (s_r.st == CSC_ST_WAKE);
	assign domain_en.core_clock = sys_tick & run_on; // R11 R12
	assign domain_en.program_memory_clock = sys_tick & run_on; // R13
	assign domain_en.peripheral_clock = sys_tick
		& (run_on | (slp & s_r.mode == CSC_SLP_IDLE)); // R12
	assign domain_en.converter_clock = sys_tick & (run_on | (slp
		& (s_r.mode == CSC_SLP_IDLE || s_r.mode == CSC_SLP_CONV))); // R15
	assign domain_en.async_timer_clock = async_source_tick
		& (run_on | (slp & s_r.mode != CSC_SLP_PDOWN)); // R14

	assign internal_reset = s_r.reset_o;
	assign wake_interrupt = s_r.wake_irq;
	assign lp_freq_range = is_lp(s_r.fz)
		? s_r.fz.clock_source_select_fuses[3:1] : 3'h0; // R08

	assign s_axi_awready = !s_r.aw_got;
	assign s_axi_wready = !s_r.w_got;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
endmodule

// ### design/csc_pkg.sv
// package of constants, types and layouts for the clock source control
// assumes one 50 MHz bus clock and synchronous oscillator tick pulses
package csc_pkg;

	// fuse encodings, '0' is programmed
	localparam logic [3:0] CSC_SRC_EXT       = 4'h0;
	localparam logic [3:0] CSC_SRC_RESERVED  = 4'h1;
	localparam logic [3:0] CSC_SRC_RC_CAL    = 4'h2;
	localparam logic [3:0] CSC_SRC_RC_128K   = 4'h3;
	localparam logic [3:0] CSC_SRC_LF_LO     = 4'h4;
	localparam logic [3:0] CSC_SRC_FS_LO     = 4'h6;
	localparam logic [3:0] CSC_SRC_LP_LO     = 4'h8;
	localparam logic       CSC_FUSE_PROG     = 1'b0;

	// factory default fuse values
	localparam logic [3:0] CSC_DEF_SRC_SEL   = 4'h2;
	localparam logic [1:0] CSC_DEF_SUT       = 2'h2;
	localparam logic       CSC_DEF_DIV8      = 1'b0;

	// prescaler ratio with the divide fuse programmed
	localparam int         CSC_DIV_RATIO     = 8;

	// watchdog oscillator time-out counts
	localparam logic [14:0] CSC_TOUT_NONE    = 15'h0000;
	localparam logic [14:0] CSC_TOUT_SHORT   = 15'h0200;
	localparam logic [14:0] CSC_TOUT_LONG    = 15'h2000;

	// oscillator start-up counts
	localparam logic [14:0] CSC_SU_258       = 15'h0102;
	localparam logic [14:0] CSC_SU_1K        = 15'h0400;
	localparam logic [14:0] CSC_SU_16K       = 15'h4000;
	localparam logic [14:0] CSC_SU_EXT       = 15'h0006;
	localparam logic [14:0] CSC_RESET_EXTRA  = 15'h000E;

	// sleep modes
	typedef enum logic [2:0]
	{
		CSC_SLP_IDLE   = 3'h0,
		CSC_SLP_CONV   = 3'h1,
		CSC_SLP_PDOWN  = 3'h2,
		CSC_SLP_PSAVE  = 3'h3
	} csc_sleep_t;

	// start-up sequence, gray from hold to wake on the low power crystal path
	typedef enum logic [2:0]
	{
		CSC_ST_HOLD    = 3'b000,
		CSC_ST_TOUT    = 3'b001,
		CSC_ST_EXTRA   = 3'b011,
		CSC_ST_START   = 3'b010,
		CSC_ST_RUN     = 3'b110,
		CSC_ST_SLEEP   = 3'b111,
		CSC_ST_WAKE    = 3'b101
	} csc_state_t;

	// fuse set as sampled during reset
	typedef struct packed
	{
		logic [3:0] clock_source_select_fuses;
		logic [1:0] startup_time_fuses;
		logic       divide_by_eight_fuse;
	} csc_fuse_t;

	// clock domain enable pulses
	typedef struct packed
	{
		logic core_clock;
		logic peripheral_clock;
		logic program_memory_clock;
		logic async_timer_clock;
		logic converter_clock;
	} csc_domain_t;

	// register map
	localparam logic [3:0] CSC_REG_CTRL      = 4'h0;
	localparam logic [3:0] CSC_REG_STATUS    = 4'h4;
	localparam int         CSC_CTRL_GO_BIT   = 3;
	localparam logic [1:0] CSC_RESP_OKAY     = 2'h0;
	localparam logic [1:0] CSC_RESP_SLVERR   = 2'h2;

endpackage

// ### design/csc_prescaler.sv
// system clock prescaler: one enable per oscillator tick, or per eighth
// assumes osc_tick is a one-cycle pulse synchronous to aclk
`timescale 1ns/1ns
module csc_prescaler
#(
	parameter int RATIO = csc_pkg::CSC_DIV_RATIO
)
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic divide,
	input  wire logic osc_tick,
	output logic      sys_tick
);
	import csc_pkg::*;

	typedef struct packed
	{
		logic [$clog2(RATIO)-1:0] cnt;
		logic                     tick;
	} csc_pre_state_t;

	csc_pre_state_t s_r;
	csc_pre_state_t s_nxt;

	// count oscillator ticks, emit on wrap when dividing
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (osc_tick)
		begin
			if (!divide)
				s_nxt.tick = 1'b1;
			else if (s_r.cnt == ($clog2(RATIO))'(RATIO - 1))
			begin
				s_nxt.cnt = '0;
				s_nxt.tick = 1'b1; // R17
			end
			else
				s_nxt.cnt = s_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign sys_tick = s_r.tick;
endmodule

// ### verif/csc_clock_control_properties.sv
// checker of start-up, gating and bus answer timing at the top ports
// assumes one clock domain and a synchronous active low reset
`timescale 1ns/1ns
module csc_clock_control_properties
(
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire logic                 wake_level,
	input wire logic                 internal_reset,
	input wire csc_pkg::csc_domain_t domain_en,
	input wire logic                 wake_interrupt,
	input wire logic [2:0]           lp_freq_range
);
	import csc_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// domain gating against reset and against each other, and the frequency range code
	a_core_held: assert property (
		internal_reset |-> !domain_en.core_clock)
		else $error("core clock ran in reset");
	a_flash_core: assert property (
		domain_en.program_memory_clock == domain_en.core_clock)
		else $error("program memory clock split from core");
	a_same_rate: assert property (
		domain_en.core_clock |->
		domain_en.peripheral_clock && domain_en.converter_clock)
		else $error("domains off the prescaler rate");
	a_lp_range: assert property (
		lp_freq_range != 3'h0 |-> lp_freq_range[2])
		else $error("bad frequency range code");
	// reset release and wake behaviour
	a_reset_stays: assert property (
		$fell(internal_reset) |=> !internal_reset [*8])
		else $error("internal reset came back");
	a_wake_pulse: assert property (
		wake_interrupt |=> !wake_interrupt)
		else $error("wake interrupt longer than a cycle");
	a_wake_level: assert property (
		wake_interrupt |-> $past(wake_level))
		else $error("wake interrupt without held level");
	a_wake_run: assert property (
		wake_interrupt |-> !internal_reset)
		else $error("wake interrupt while in reset");
	// read channel answer and hold
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (
		s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
endmodule

bind csc_clock_control csc_clock_control_properties chk_u
(
	.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .wake_level, .internal_reset,
	.domain_en, .wake_interrupt, .lp_freq_range
);

// ### verif/csc_clock_control_test.sv
// bench: start-up counts per fuse set, sleep gating, wake, bus
// assumes the oscillator model ticks every second cycle
`timescale 1ns/1ns
module csc_clock_control_test;
	import csc_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, wake_level = 1'b0;
	logic        other_reset_active = 1'b1, wake_event = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	csc_fuse_t   fuses = 7'h14;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, internal_reset;
	logic        wake_interrupt, osc_tick, watchdog_tick;
	logic        async_source_tick;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, d;
	logic [1:0]  r;
	logic [2:0]  lp_freq_range;
	logic [4:0]  seen;
	csc_domain_t domain_en;
	logic [4:0]  mask [4] = '{5'h0B, 5'h03, 5'h00, 5'h02};
	int          n_errors = 0, n_checks = 0, k, m;

	always #10 aclk = ~aclk;

	csc_osc_model osc_u (.aclk, .osc_tick, .watchdog_tick,
		.async_source_tick);

	csc_clock_control dut_u (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fuses,
		.other_reset_active, .osc_tick, .watchdog_tick, .async_source_tick,
		.wake_event, .wake_level, .internal_reset, .domain_en,
		.wake_interrupt, .lp_freq_range);

	// verdict and end of run
	task end_of_test;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// compare and count
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// bounded wait ran out
	task hang(input int n);
		if (n >= 400)
		begin
			n_errors++;
			end_of_test();
		end
	endtask

	// bus write, address and data offered together
	task wr(input logic [3:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 400; k++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		hang(k);
	endtask

	// bus read, rready raised only once rvalid has been seen
	task rd(input logic [3:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (k = 0; k < 400; k++)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
			s_axi_rready <= s_axi_rvalid === 1'b1;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		hang(k);
	endtask

	// reset with a fuse set, time the release, check rate
	task boot(input logic [6:0] f, input int e, input logic [2:0] g);
		aresetn <= 1'b0;
		fuses <= f;
		other_reset_active <= 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		other_reset_active <= 1'b0;
		for (k = 0; k < 40000 && internal_reset !== 1'b0; k++)
			@(posedge aclk);
		if (k >= 40000) hang(k);
		chk(k >= e - 2 && k <= e + 8, 1);
		chk(lp_freq_range, g);
		rd(4'h4);
		chk(d[10:0], {4'hC, f});
		m = 0;
		repeat (160)
		begin
			@(posedge aclk);
			m += domain_en.core_clock;
		end
		chk(m, f[0] ? 80 : 10);
	endtask

	initial
	begin
		boot(7'h53, 8736, 3'h5);
		boot(7'h6B, 32796, 3'h6);
		boot(7'h31, 2048, 3'h0);
		boot(7'h03, 524, 3'h0);
		boot(7'h14, 8204, 3'h0);
		rd(4'h8);
		chk(d, 32'h0);
		chk(r, CSC_RESP_SLVERR);
		// unmapped write answers an error, state stays running
		wr(4'h8, 32'h0);
		chk(r, CSC_RESP_SLVERR);
		// every sleep mode, then wake on a held level
		for (m = 0; m < 4; m++)
		begin
			wr(CSC_REG_CTRL, 32'h8 | m);
			chk(r, CSC_RESP_OKAY);
			rd(CSC_REG_STATUS);
			chk(d[10:8], 3'h7);
			seen = 5'h00;
			repeat (64)
			begin
				@(posedge aclk);
				seen = seen | domain_en;
			end
			chk(seen, mask[m]);
			wake_level <= 1'b1;
			for (k = 0; k < 400 && wake_interrupt !== 1'b1; k++)
				@(posedge aclk);
			hang(k);
			chk(k >= 10 && k <= 24, 1);
			wake_level <= 1'b0;
		end
		// level dropped early: wakes without interrupt
		wr(CSC_REG_CTRL, 32'hA);
		wake_level <= 1'b1;
		@(posedge aclk);
		wake_level <= 1'b0;
		seen = 5'h00;
		repeat (60)
		begin
			@(posedge aclk);
			seen[0] = seen[0] | wake_interrupt;
		end
		chk(seen[0], 0);
		fuses <= 7'h7F;
		rd(CSC_REG_STATUS);
		chk(d[10:0], 11'h614);
		// power-save left on a wake pulse: start-up only, no interrupt
		wr(CSC_REG_CTRL, 32'hB);
		wake_event <= 1'b1;
		@(posedge aclk);
		wake_event <= 1'b0;
		seen = 5'h00;
		repeat (40)
		begin
			@(posedge aclk);
			seen[0] = seen[0] | wake_interrupt;
		end
		chk(seen[0], 0);
		rd(CSC_REG_STATUS);
		chk(d[10:8], 3'h6);
		end_of_test();
	end
endmodule

// ### verif/csc_osc_model.sv
// oscillator side model: selected, watchdog and async source ticks
// assumes aclk is at least as fast as every modelled source
`timescale 1ns/1ns
module csc_osc_model
#(
	parameter int OSC_GAP = 2
)
(
	input  wire logic aclk,
	output logic      osc_tick = 1'b0,
	output logic      watchdog_tick = 1'b0,
	output logic      async_source_tick = 1'b0
);
	logic [7:0] cnt_r = 8'h00;

	// free running source cycles, selected oscillator every OSC_GAP
	always @(posedge aclk)
	begin
		cnt_r <= cnt_r + 8'h01;
		osc_tick <= (cnt_r % OSC_GAP) == 0;
		watchdog_tick <= 1'b1;
		async_source_tick <= cnt_r[1:0] == 2'h0;
	end
endmodule
